// [hdl/cpusb_pkg.sv]
`default_nettype none
package cpusb_pkg;

    // ------------------------------------------------------------
    // Synchroniser and timing counts
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam int DBG_ENTRY_CYCLES = 4;
    localparam int BUILTIN_SELF_TEST_CYCLES = 16;

    // ------------------------------------------------------------
    // Async sideband input bit positions
    // ------------------------------------------------------------
    localparam int ASYNC_W = 5;
    localparam int POS_INIT = 0;
    localparam int POS_IRQ_LINE0 = 1;
    localparam int POS_IRQ_LINE1 = 2;
    localparam int POS_PROBE_REQ = 3;
    localparam int POS_PRIO_REQ = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic LIC_EN_RESET = 1'b1;
    // Synchroniser image of every async sideband pin at its inactive level
    localparam logic [ASYNC_W-1:0] SYNC_IDLE = 5'h19;
    localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'hFFFFFFF0;

    typedef enum logic [2:0] {
        CPUSB_RUN,
        CPUSB_RESET,
        CPUSB_BUILTIN_SELF_TEST,
        CPUSB_INIT,
        CPUSB_DEBUG
    } cpusb_state_type;

    // Requests toward the core
    typedef struct packed {
        logic clear_int_regs;
        logic restart_fetch;
        logic maskable_irq_req;
        logic nmi_req;
        logic line0_event;
        logic line1_event;
    } cpusb_core_req_type;

endpackage
`default_nettype wire

// [hdl/cpusb_sideband.sv]
// Functional notes
// - Soft init asserted clears integer registers; caches, FP state kept.
// - After soft init, restart fetch at the configured reset vector.
// - Keep answering system bus snoops throughout soft init.
// - Soft init active at hard reset release runs built-in self-test.
// - Controller disabled: line0 is maskable request, line1 is nonmaskable.
// - Both local interrupt lines are asynchronous inputs.
// - Software setting of the controller selects legacy or local use.
// - Local interrupt controller enabled after reset.
// - Bus lock held from first to last transaction of atomic sequence.
// - Drive probe ready to tell debug tools debug readiness.
// - Accept probe request as request to enter debug operation.
`timescale 1ns/1ps
`default_nettype none

module cpusb_sideband
    import cpusb_pkg::*;
#(
    parameter int BUILTIN_SELF_TEST_LEN = cpusb_pkg::BUILTIN_SELF_TEST_CYCLES,
    parameter int DBG_LEN = cpusb_pkg::DBG_ENTRY_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    // Hardware reset from the system, asynchronous, active low
    input wire logic hard_reset_n_in,
    // Soft initialization pin, asynchronous, active low
    input wire logic soft_init_n_in,
    input wire logic [1:0] local_irq_pins_in,
    input wire logic probe_request_n_in,
    input wire logic priority_bus_request_n_in,
    // Software view of the controller enable bit
    input wire logic lic_cfg_wr_in,
    input wire logic lic_cfg_en_in,
    input wire logic [31:0] cfg_reset_vector_in,
    // Core side of the atomic sequence
    input wire logic lock_seq_start_in,
    input wire logic lock_seq_end_in,
    input wire logic core_idle_in,
    input wire logic snoop_req_in,
    output logic snoop_ack_out,
    output logic lock_n_out,
    output logic lock_oe_out,
    output logic probe_ready_n_out,
    output logic lic_enabled_out,
    output logic builtin_self_test_busy_out,
    output logic [31:0] fetch_vector_out,
    output cpusb_pkg::cpusb_core_req_type core_req_out
);
    import cpusb_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [ASYNC_W-1:0] async_raw;
    logic [ASYNC_W-1:0] meta_q;
    logic [ASYNC_W-1:0] sync_q;
    logic hrst_meta_q;
    logic hrst_sync_q;
    logic hrst_prev_q;

    assign async_raw = {priority_bus_request_n_in, probe_request_n_in,
                        local_irq_pins_in[1], local_irq_pins_in[0],
                        soft_init_n_in};

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            meta_q <= SYNC_IDLE;
            sync_q <= SYNC_IDLE;
            hrst_meta_q <= 1'b0;
            hrst_sync_q <= 1'b0;
        end else if (clk_en_in) begin
            meta_q <= async_raw;
            sync_q <= meta_q;
            hrst_meta_q <= hard_reset_n_in;
            hrst_sync_q <= hrst_meta_q;
        end
    end

    logic init_act;
    logic line0_s;
    logic line1_s;
    logic probe_req_act;
    logic prio_req_act;
    assign init_act = ~sync_q[POS_INIT];
    assign line0_s = sync_q[POS_IRQ_LINE0];
    assign line1_s = sync_q[POS_IRQ_LINE1];
    assign probe_req_act = ~sync_q[POS_PROBE_REQ];
    assign prio_req_act = ~sync_q[POS_PRIO_REQ];

    // ------------------------------------------------------------
    // Interrupt controller enable
    // ------------------------------------------------------------
    logic lic_en_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lic_en_q <= LIC_EN_RESET;
        end else if (clk_en_in) begin
            if (!hrst_sync_q) begin
                lic_en_q <= LIC_EN_RESET;
            end else if (lic_cfg_wr_in) begin
                lic_en_q <= lic_cfg_en_in;
            end
        end
    end
    assign lic_enabled_out = lic_en_q;

    // ------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------
    logic line0_prev_q;
    logic line1_prev_q;
    logic mask_req_q;
    logic nmi_q;
    logic ev0_q;
    logic ev1_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            line0_prev_q <= 1'b0;
            line1_prev_q <= 1'b0;
            mask_req_q <= 1'b0;
            nmi_q <= 1'b0;
            ev0_q <= 1'b0;
            ev1_q <= 1'b0;
        end else if (clk_en_in) begin
            line0_prev_q <= line0_s;
            line1_prev_q <= line1_s;
            mask_req_q <= ~lic_en_q & line0_s;
            nmi_q <= ~lic_en_q & line1_s & ~line1_prev_q;
            // Local mode hands raw edges to the controller
            ev0_q <= lic_en_q & line0_s & ~line0_prev_q;
            ev1_q <= lic_en_q & line1_s & ~line1_prev_q;
        end
    end

    // ------------------------------------------------------------
    // Reset, self-test and soft init sequencing
    // ------------------------------------------------------------
    cpusb_state_type state_q;
    logic [15:0] cnt_q;
    logic [31:0] vec_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            hrst_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            hrst_prev_q <= hrst_sync_q;
        end
    end

    // Vector caught at hard reset release, not from a port under reset
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            vec_q <= RESET_VECTOR_DEFAULT;
        end else if (clk_en_in && hrst_sync_q && !hrst_prev_q) begin
            vec_q <= cfg_reset_vector_in;
        end
    end
    assign fetch_vector_out = vec_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_q <= CPUSB_RESET;
            cnt_q <= 16'h0000;
        end else if (clk_en_in) begin
            if (!hrst_sync_q) begin
                state_q <= CPUSB_RESET;
                cnt_q <= 16'h0000;
            end else begin
                unique case (state_q)
                    CPUSB_RESET: begin
                        if (init_act) begin
                            state_q <= CPUSB_BUILTIN_SELF_TEST;
                            cnt_q <= 16'(BUILTIN_SELF_TEST_LEN - 1);
                        end else begin
                            state_q <= CPUSB_RUN;
                        end
                    end
                    CPUSB_BUILTIN_SELF_TEST: begin
                        if (cnt_q == 16'h0000) begin
                            state_q <= CPUSB_RUN;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                    CPUSB_RUN: begin
                        if (init_act) begin
                            state_q <= CPUSB_INIT;
                        end else if (probe_req_act && core_idle_in) begin
                            state_q <= CPUSB_DEBUG;
                            cnt_q <= 16'(DBG_LEN - 1);
                        end
                    end
                    CPUSB_INIT: begin
                        if (!init_act) begin
                            state_q <= CPUSB_RUN;
                        end
                    end
                    CPUSB_DEBUG: begin
                        if (cnt_q != 16'h0000) begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                        // soft init still wins in debug
                        if (init_act) begin
                            state_q <= CPUSB_INIT;
                        end else if (!probe_req_act) begin
                            state_q <= CPUSB_RUN;
                        end
                    end
                endcase
            end
        end
    end

    assign builtin_self_test_busy_out = (state_q == CPUSB_BUILTIN_SELF_TEST);

    // ------------------------------------------------------------
    // Core requests
    // ------------------------------------------------------------
    logic restart_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            restart_q <= 1'b0;
        end else if (clk_en_in) begin
            restart_q <= (state_q == CPUSB_INIT) && !init_act;
        end
    end

    always_comb begin
        core_req_out = '0;
        core_req_out.clear_int_regs = (state_q == CPUSB_INIT);
        core_req_out.restart_fetch = restart_q;
        core_req_out.maskable_irq_req = mask_req_q;
        core_req_out.nmi_req = nmi_q;
        core_req_out.line0_event = ev0_q;
        core_req_out.line1_event = ev1_q;
    end

    // snoops during init
    // Snoop answer depends on hard reset only, not state_q, so soft init never blocks it
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            snoop_ack_out <= 1'b0;
        end else if (clk_en_in) begin
            snoop_ack_out <= snoop_req_in && hrst_sync_q;
        end
    end

    // ------------------------------------------------------------
    // Bus lock
    // ------------------------------------------------------------
    logic lock_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lock_q <= 1'b0;
        end else if (clk_en_in) begin
            if (!hrst_sync_q) begin
                lock_q <= 1'b0;
            end else if (lock_seq_start_in) begin
                lock_q <= 1'b1;
            end else if (lock_seq_end_in) begin
                lock_q <= 1'b0;
            end
        end
    end
    // priority agent waits
    // Open-drain style: drive low only while locked; the priority agent
    // sees it released and may then own the bus. Its request is only
    // synchronised here, since the waiting is the far agent's duty.
    assign lock_n_out = ~lock_q;
    assign lock_oe_out = lock_q | (prio_req_act & 1'b0);

    // ------------------------------------------------------------
    // Debug probe
    // ------------------------------------------------------------
    logic probe_rdy_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            probe_rdy_q <= 1'b0;
        end else if (clk_en_in) begin
            probe_rdy_q <= (state_q == CPUSB_DEBUG) && (cnt_q == 16'h0000);
        end
    end
    assign probe_ready_n_out = ~probe_rdy_q;

endmodule // cpusb_sideband

`default_nettype wire

// [bench/cpusb_sideband_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cpusb_sideband_monitor
    import cpusb_pkg::*;
#(
    parameter int BUILTIN_SELF_TEST_LEN = 16
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic hard_reset_n_in,
    input wire logic soft_init_n_in,
    input wire logic [1:0] local_irq_pins_in,
    input wire logic probe_request_n_in,
    input wire logic lock_seq_start_in,
    input wire logic lock_seq_end_in,
    input wire logic snoop_req_in,
    input wire logic snoop_ack_out,
    input wire logic lock_n_out,
    input wire logic lock_oe_out,
    input wire logic probe_ready_n_out,
    input wire logic lic_enabled_out,
    input wire logic builtin_self_test_busy_out,
    input wire cpusb_pkg::cpusb_core_req_type core_req_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Cycles of the running self-test; cleared once it ends
    int run_q;
    always_ff @(posedge clk_in) begin
        if (rstn_in && builtin_self_test_busy_out) begin
            run_q <= run_q + 1;
        end else begin
            run_q <= 0;
        end
    end
    a_lock_take: assert property (
        lock_seq_start_in && $past(hard_reset_n_in, 2) |=> !lock_n_out)
        else $error("no lock");
    a_lock_drop: assert property (
        lock_seq_end_in && !lock_seq_start_in |=> lock_n_out) else $error("lock kept");
    a_lock_stand: assert property (
        !lock_n_out && !lock_seq_end_in && $past(hard_reset_n_in, 2)
        |=> !lock_n_out) else $error("lock lost");
    a_lock_oe: assert property (lock_oe_out == !lock_n_out)
        else $error("lock enable wrong");
    a_snoop_ack: assert property (
        snoop_req_in && $past(hard_reset_n_in, 2) && $past(hard_reset_n_in, 3)
        |=> snoop_ack_out) else $error("snoop unanswered");
    a_irq_level: assert property (
        (!lic_enabled_out)[*4] |-> core_req_out.maskable_irq_req
        == $past(local_irq_pins_in[0], 3)) else $error("maskable wrong");
    a_local_mode: assert property (
        lic_enabled_out[*4] |-> !core_req_out.maskable_irq_req
        && !core_req_out.nmi_req) else $error("legacy irq while enabled");
    a_probe_idle: assert property (
        probe_request_n_in[*5] |-> probe_ready_n_out) else $error("ready unasked");
    a_clear_hold: assert property (
        (!soft_init_n_in && hard_reset_n_in && !builtin_self_test_busy_out)[*5]
        |-> core_req_out.clear_int_regs) else $error("clear missing");
    a_clear_drop: assert property (
        soft_init_n_in[*5] |-> !core_req_out.clear_int_regs) else $error("clear stuck");
    a_builtin_self_test_len: assert property (
        $fell(builtin_self_test_busy_out) |-> run_q == BUILTIN_SELF_TEST_LEN) else $error("self-test length");
endmodule // cpusb_sideband_monitor
bind cpusb_sideband cpusb_sideband_monitor #(.BUILTIN_SELF_TEST_LEN(BUILTIN_SELF_TEST_LEN)) u_mon (
    .clk_in, .rstn_in, .hard_reset_n_in, .soft_init_n_in, .local_irq_pins_in,
    .probe_request_n_in, .lock_seq_start_in, .lock_seq_end_in, .snoop_req_in,
    .snoop_ack_out, .lock_n_out, .lock_oe_out, .probe_ready_n_out,
    .lic_enabled_out, .builtin_self_test_busy_out, .core_req_out);
`default_nettype wire

// [bench/cpusb_agent_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpusb_agent_model (
    input wire logic clk_in,
    input wire logic lock_wire_in,
    input wire logic want_bus_in,
    output logic priority_bus_request_n_out,
    output logic owns_bus_out
);
    always_ff @(posedge clk_in) begin
        priority_bus_request_n_out <= !want_bus_in;
    end
    always_ff @(posedge clk_in) begin
        owns_bus_out <= want_bus_in && (owns_bus_out
            || (!priority_bus_request_n_out && lock_wire_in));
    end
endmodule // cpusb_agent_model
`default_nettype wire

// [bench/cpusb_sideband_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cpusb_sideband_bench;
    import cpusb_pkg::*;
    localparam int BL = 6;
    localparam logic [31:0] VEC = 32'h00001234;
    logic clk_in = 1'b0, rstn_in = 1'b0, hrst_n = 1'b0, sinit_n = 1'b1;
    logic probe_request_n_n = 1'b1, wr = 1'b0, en = 1'b1, start = 1'b0, stop = 1'b0;
    logic idle = 1'b0, snp = 1'b0, want = 1'b0;
    logic [1:0] irq = 2'b00;
    logic pri_n, owns, ack, lock_n, lock_oe, probe_ready_n_n, lic, busy, lock_wire;
    logic [31:0] vec, n_l0, n_l1, n_nmi, n_rst, n_mask;
    cpusb_core_req_type req;
    int fail_count = 0;
    int checks = 0;
    // Pull-up on the open-drain lock line
    assign lock_wire = lock_oe ? 1'b0 : 1'b1;
    cpusb_sideband #(.BUILTIN_SELF_TEST_LEN(BL), .DBG_LEN(2)) dut (.clk_in, .rstn_in,
        .clk_en_in(1'b1), .hard_reset_n_in(hrst_n), .soft_init_n_in(sinit_n),
        .local_irq_pins_in(irq), .probe_request_n_in(probe_request_n_n),
        .priority_bus_request_n_in(pri_n), .lic_cfg_wr_in(wr),
        .lic_cfg_en_in(en), .cfg_reset_vector_in(VEC),
        .lock_seq_start_in(start), .lock_seq_end_in(stop), .core_idle_in(idle),
        .snoop_req_in(snp), .snoop_ack_out(ack), .lock_n_out(lock_n),
        .lock_oe_out(lock_oe), .probe_ready_n_out(probe_ready_n_n),
        .lic_enabled_out(lic), .builtin_self_test_busy_out(busy), .fetch_vector_out(vec),
        .core_req_out(req));
    cpusb_agent_model u_agent (.clk_in, .lock_wire_in(lock_wire),
        .want_bus_in(want), .priority_bus_request_n_out(pri_n),
        .owns_bus_out(owns));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Counts core request pulses and maskable level over n cycles
    task automatic watch(input int n);
        {n_l0, n_l1, n_nmi, n_rst, n_mask} = '0;
        repeat (n) begin
            tick(1);
            n_l0 += req.line0_event;
            n_l1 += req.line1_event;
            n_nmi += req.nmi_req;
            n_rst += req.restart_fetch;
            n_mask += req.maskable_irq_req;
        end
    endtask
    task automatic t_boot();
        chk(lic, 1'b1);
        chk(lock_wire, 1'b1);
        hrst_n = 1'b1;
        tick(8);
        chk(vec, VEC);
        chk(busy, 1'b0);
    endtask
    task automatic t_soft();
        sinit_n = 1'b0;
        tick(4);
        chk(req.clear_int_regs, 1'b1);
        snp = 1'b1;
        tick(1);
        snp = 1'b0;
        chk(ack, 1'b1);
        sinit_n = 1'b1;
        watch(6);
        chk(n_rst, 32'h1);
        chk(req.clear_int_regs, 1'b0);
        chk(vec, VEC);
    endtask
    task automatic t_lock();
        start = 1'b1;
        tick(1);
        start = 1'b0;
        chk(lock_wire, 1'b0);
        want = 1'b1;
        tick(5);
        chk(owns, 1'b0);
        chk(lock_wire, 1'b0);
        stop = 1'b1;
        tick(1);
        stop = 1'b0;
        chk(lock_wire, 1'b1);
        tick(3);
        chk(owns, 1'b1);
        want = 1'b0;
    endtask
    task automatic t_probe();
        int n;
        probe_request_n_n = 1'b0;
        tick(8);
        chk(probe_ready_n_n, 1'b1);
        idle = 1'b1;
        for (n = 0; n < 20 && probe_ready_n_n !== 1'b0; n++) tick(1);
        chk(probe_ready_n_n, 1'b0);
        probe_request_n_n = 1'b1;
        tick(4);
        chk(probe_ready_n_n, 1'b1);
    endtask
    task automatic t_builtin_self_test();
        int n;
        hrst_n = 1'b0;
        sinit_n = 1'b0;
        tick(4);
        hrst_n = 1'b1;
        for (n = 0; n < 20 && busy !== 1'b1; n++) tick(1);
        sinit_n = 1'b1;
        for (n = 0; n < 100 && busy === 1'b1; n++) tick(1);
        chk(n, BL);
        tick(6);
    endtask
    task automatic t_irq();
        irq = 2'b11;
        watch(6);
        chk({n_l0[7:0], n_l1[7:0], n_mask[7:0], n_nmi[7:0]}, 32'h01010000);
        irq = 2'b00;
        wr = 1'b1;
        en = 1'b0;
        tick(1);
        wr = 1'b0;
        tick(5);
        chk(lic, 1'b0);
        irq = 2'b11;
        watch(6);
        chk(n_mask, 32'h4);
        chk(n_nmi, 32'h1);
    endtask
    task automatic final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(2000 * 50);
        fail_count++;
        final_report();
    end
    initial begin
        tick(20);
        rstn_in = 1'b1;
        t_boot();
        t_soft();
        t_lock();
        t_probe();
        t_builtin_self_test();
        t_irq();
        final_report();
    end
endmodule // cpusb_sideband_bench
`default_nettype wire
